// *** hw/sulp_pkg.sv ***
`default_nettype none

package sulp_pkg;

  // operating modes of the update path
  typedef enum logic [1:0] {
    SULP_MODE_SINGLE  = 2'b00,
    SULP_MODE_PROFILE = 2'b01,
    SULP_MODE_SWEEP   = 2'b10
  } sulp_mode_t;

  // word widths
  localparam int FREQ_W = 32;
  localparam int PHASE_W = 14;
  localparam int AMP_W = 10;
  localparam int PROF_W = 4;

  // pipeline latencies in core sample clock cycles
  localparam int LAT_ST_MATCHED = 29;
  localparam int LAT_ST_FREQ = 29;
  localparam int LAT_ST_PHASE = 25;
  localparam int LAT_ST_AMP = 17;
  localparam int LAT_PR_FREQ = 34;
  localparam int LAT_PR_PHASE = 29;
  localparam int LAT_PR_AMP = 21;
  localparam int LAT_SW_FREQ = 41;
  localparam int LAT_SW_PHASE = 37;
  localparam int LAT_SW_AMP = 29;

  // longest delay line needed; the output flop adds the last cycle
  localparam int LAT_MAX = 41;

  // reset values
  localparam logic [FREQ_W-1:0] FREQ_RST = 32'h0000_0000;
  localparam logic [PHASE_W-1:0] PHASE_RST = 14'h0000;
  localparam logic [AMP_W-1:0] AMP_RST = 10'h000;

endpackage

`default_nettype wire

// *** hw/sulp_delay_line.sv ***
`timescale 1ns/1ns
`default_nettype none

// tapped shift register; tap k gives the input delayed by k cycles
module sulp_delay_line #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // data
  input  wire logic [W-1:0]         din,
  output logic [DEPTH:1][W-1:0]     taps
);

  // one stage per cycle; a generate keeps each stage a plain flop
  genvar g;
  generate
    for (g = 1; g <= DEPTH; g++) begin : g_stage
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          taps[g] <= '0;
        end else if (g == 1) begin
          taps[g] <= din;
        end else begin
          taps[g] <= taps[(g > 1) ? g-1 : 1];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// *** hw/sulp_top.sv ***
//Behaviour
// - matched single-tone: all words after 29
// - single-tone unmatched frequency after 29 cycles
// - single-tone unmatched phase after 25 cycles
// - single-tone unmatched amplitude after 17 cycles
// - profile mode: 34, 29, 21 cycles
// - sweep steps: 41, 37, 29 cycles
// - single-tone counts from commit strobe
// - every delay fixed, never varies
// - profile and sweep count from profile change
// - commit sampled on rising sync edge
`timescale 1ns/1ns
`default_nettype none

module sulp_top (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // mode control, static while running
  input  wire logic [1:0]                  mode,
  input  wire logic                        match_en,
  // pending words, written ahead of the strobe
  input  wire logic [sulp_pkg::FREQ_W-1:0]  freq_word,
  input  wire logic [sulp_pkg::PHASE_W-1:0] phase_word,
  input  wire logic [sulp_pkg::AMP_W-1:0]   amp_word,
  // commit strobe and profile pins from the controller
  input  wire logic                        commit,
  input  wire logic [sulp_pkg::PROF_W-1:0]  profile,
  // words at the converter
  output logic [sulp_pkg::FREQ_W-1:0]       out_freq_r,
  output logic [sulp_pkg::PHASE_W-1:0]      out_phase_r,
  output logic [sulp_pkg::AMP_W-1:0]        out_amp_r,
  // one-cycle marks when a new word lands
  output logic                             freq_upd_r,
  output logic                             phase_upd_r,
  output logic                             amp_upd_r
);

  localparam int DW = sulp_pkg::FREQ_W + sulp_pkg::PHASE_W
                      + sulp_pkg::AMP_W + 1;

  // pin synchronisers: first stage read only by the second
  logic                         commit_s1_r;
  logic                         commit_s2_r;
  logic                         commit_d_r;
  logic [sulp_pkg::PROF_W-1:0]  prof_s1_r;
  logic [sulp_pkg::PROF_W-1:0]  prof_s2_r;
  logic [sulp_pkg::PROF_W-1:0]  prof_d_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      commit_s1_r <= 1'b0;
      commit_s2_r <= 1'b0;
      commit_d_r  <= 1'b0;
      prof_s1_r   <= '0;
      prof_s2_r   <= '0;
      prof_d_r    <= '0;
    end else begin
      commit_s1_r <= commit;
      commit_s2_r <= commit_s1_r;
      commit_d_r  <= commit_s2_r;
      prof_s1_r   <= profile;
      prof_s2_r   <= prof_s1_r;
      prof_d_r    <= prof_s2_r;
    end
  end

  // trigger event selection by mode
  logic trig;
  always_comb begin
    trig = 1'b0;
    case (sulp_pkg::sulp_mode_t'(mode))
      sulp_pkg::SULP_MODE_SINGLE: trig = commit_s2_r & ~commit_d_r;
      sulp_pkg::SULP_MODE_PROFILE,
      sulp_pkg::SULP_MODE_SWEEP:  trig = (prof_s2_r != prof_d_r);
      default:                    trig = 1'b0;
    endcase
  end

  // words captured with the trigger; a long strobe counts once
  // since only its rising edge triggers
  logic [DW-1:0] din;
  assign din = {trig, freq_word, phase_word, amp_word};

  // all three words travel one shared delay line
  logic [sulp_pkg::LAT_MAX:1][DW-1:0] taps;

  sulp_delay_line #(
    .W     (DW),
    .DEPTH (sulp_pkg::LAT_MAX)
  ) sulp_delay_line_i (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (din),
    .taps  (taps)
  );

  // tap choice: trigger latched at synchroniser output counts as
  // cycle 0, the tap gives k-1, the output flop adds one more
  int lat_f;
  int lat_p;
  int lat_a;
  always_comb begin
    lat_f = sulp_pkg::LAT_ST_FREQ;
    lat_p = sulp_pkg::LAT_ST_PHASE;
    lat_a = sulp_pkg::LAT_ST_AMP;
    case (sulp_pkg::sulp_mode_t'(mode))
      sulp_pkg::SULP_MODE_SINGLE: begin
        if (match_en) begin
          lat_f = sulp_pkg::LAT_ST_MATCHED;
          lat_p = sulp_pkg::LAT_ST_MATCHED;
          lat_a = sulp_pkg::LAT_ST_MATCHED;
        end else begin
          lat_f = sulp_pkg::LAT_ST_FREQ;
          lat_p = sulp_pkg::LAT_ST_PHASE;
          lat_a = sulp_pkg::LAT_ST_AMP;
        end
      end
      sulp_pkg::SULP_MODE_PROFILE: begin
        lat_f = sulp_pkg::LAT_PR_FREQ;
        lat_p = sulp_pkg::LAT_PR_PHASE;
        lat_a = sulp_pkg::LAT_PR_AMP;
      end
      sulp_pkg::SULP_MODE_SWEEP: begin
        lat_f = sulp_pkg::LAT_SW_FREQ;
        lat_p = sulp_pkg::LAT_SW_PHASE;
        lat_a = sulp_pkg::LAT_SW_AMP;
      end
      default: begin
        lat_f = sulp_pkg::LAT_ST_FREQ;
      end
    endcase
  end

  // selected taps; tap 0 would be din itself
  logic [DW-1:0] tf;
  logic [DW-1:0] tp;
  logic [DW-1:0] ta;
  assign tf = (lat_f > 1) ? taps[lat_f-1] : din;
  assign tp = (lat_p > 1) ? taps[lat_p-1] : din;
  assign ta = (lat_a > 1) ? taps[lat_a-1] : din;

  // field positions inside a stage
  localparam int A_LO = 0;
  localparam int P_LO = sulp_pkg::AMP_W;
  localparam int F_LO = P_LO + sulp_pkg::PHASE_W;
  localparam int V_B  = DW - 1;

  // output words update only when their delayed trigger arrives,
  // so a word change without a trigger never leaks through
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_freq_r <= sulp_pkg::FREQ_RST;
      freq_upd_r <= 1'b0;
    end else begin
      freq_upd_r <= tf[V_B];
      if (tf[V_B]) begin
        out_freq_r <= tf[F_LO +: sulp_pkg::FREQ_W];
      end
    end
  end

  // phase output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_phase_r <= sulp_pkg::PHASE_RST;
      phase_upd_r <= 1'b0;
    end else begin
      phase_upd_r <= tp[V_B];
      if (tp[V_B]) begin
        out_phase_r <= tp[P_LO +: sulp_pkg::PHASE_W];
      end
    end
  end

  // amplitude output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_amp_r <= sulp_pkg::AMP_RST;
      amp_upd_r <= 1'b0;
    end else begin
      amp_upd_r <= ta[V_B];
      if (ta[V_B]) begin
        out_amp_r <= ta[A_LO +: sulp_pkg::AMP_W];
      end
    end
  end

endmodule

`default_nettype wire

// *** testbench/sulp_host.sv ***
`timescale 1ns/1ns
`default_nettype none

// host controller: turns bench requests into pin activity
module sulp_host (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // requests from the bench
  input  wire logic       req,
  input  wire logic [3:0] prof_req,
  // pins toward the block
  output logic            commit,
  output logic [3:0]      profile
);
  logic held_r;  // second cycle of the strobe

  // edge-timed strobe
  // pins move only at the rising edge, giving a full period of setup;
  // two cycles of strobe so the synchroniser can never miss it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_r  <= 1'b0;
      commit  <= 1'b0;
      profile <= 4'h0;
    end else begin
      held_r  <= req;
      commit  <= req | held_r;
      profile <= prof_req;
    end
  end
endmodule

`default_nettype wire

// *** testbench/sulp_top_sva.sv ***
`timescale 1ns/1ns
`default_nettype none

// landing times seen from the pins, counted from the sampled trigger
module sulp_top_sva (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // controls and triggers
  input wire logic [1:0]  mode,
  input wire logic        match_en,
  input wire logic        commit,
  input wire logic [3:0]  profile,
  input wire logic [31:0] freq_word,
  // landed words and marks
  input wire logic [31:0] out_freq_r,
  input wire logic        freq_upd_r,
  input wire logic        phase_upd_r,
  input wire logic        amp_upd_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // the pin is seen one edge after it moves, the synchroniser takes
  // one more, so each landing is two edges past its latency
  st_freq_a: assert property (
    $rose(commit) && mode == 2'b00 && !match_en
    |-> ##31 freq_upd_r && out_freq_r == $past(freq_word, 29))
    else $error("single tone frequency landing wrong");
  st_phase_a: assert property (
    $rose(commit) && mode == 2'b00 && !match_en |-> ##27 phase_upd_r)
    else $error("single tone phase landing wrong");
  st_amp_a: assert property (
    $rose(commit) && mode == 2'b00 && !match_en |-> ##19 amp_upd_r)
    else $error("single tone amplitude landing wrong");
  st_match_a: assert property (
    $rose(commit) && mode == 2'b00 && match_en
    |-> ##31 freq_upd_r && phase_upd_r && amp_upd_r)
    else $error("matched words did not land together");
  pr_freq_a: assert property (
    profile != $past(profile) && mode == 2'b01 |-> ##36 freq_upd_r)
    else $error("profile frequency landing wrong");
  pr_phase_a: assert property (
    profile != $past(profile) && mode == 2'b01 |-> ##31 phase_upd_r)
    else $error("profile phase landing wrong");
  pr_amp_a: assert property (
    profile != $past(profile) && mode == 2'b01 |-> ##23 amp_upd_r)
    else $error("profile amplitude landing wrong");
  sw_freq_a: assert property (
    profile != $past(profile) && mode == 2'b10 |-> ##43 freq_upd_r)
    else $error("sweep frequency landing wrong");
  sw_phase_a: assert property (
    profile != $past(profile) && mode == 2'b10 |-> ##39 phase_upd_r)
    else $error("sweep phase landing wrong");
  sw_amp_a: assert property (
    profile != $past(profile) && mode == 2'b10 |-> ##31 amp_upd_r)
    else $error("sweep amplitude landing wrong");
endmodule

bind sulp_top sulp_top_sva sulp_top_sva_i (
  .clk         (clk),
  .rst_n       (rst_n),
  .mode        (mode),
  .match_en    (match_en),
  .commit      (commit),
  .profile     (profile),
  .freq_word   (freq_word),
  .out_freq_r  (out_freq_r),
  .freq_upd_r  (freq_upd_r),
  .phase_upd_r (phase_upd_r),
  .amp_upd_r   (amp_upd_r)
);

`default_nettype wire

// *** testbench/synth_update_latency_pipeline_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD %0t value mismatch", $time); end end

module synth_update_latency_pipeline_bench;
  logic        clk, rst_n, match_en, commit, req;  // clock, reset, controls
  logic [1:0]  mode;
  logic [3:0]  profile, prof_req;
  logic [31:0] freq_word, out_freq_r;
  logic [13:0] phase_word, out_phase_r;
  logic [9:0]  amp_word, out_amp_r;
  logic        freq_upd_r, phase_upd_r, amp_upd_r;
  int          mismatches, n_compared, fk, pk, ak;

  sulp_top sulp_top_i (
    .clk         (clk),
    .rst_n       (rst_n),
    .mode        (mode),
    .match_en    (match_en),
    .freq_word   (freq_word),
    .phase_word  (phase_word),
    .amp_word    (amp_word),
    .commit      (commit),
    .profile     (profile),
    .out_freq_r  (out_freq_r),
    .out_phase_r (out_phase_r),
    .out_amp_r   (out_amp_r),
    .freq_upd_r  (freq_upd_r),
    .phase_upd_r (phase_upd_r),
    .amp_upd_r   (amp_upd_r)
  );
  sulp_host sulp_host_i (
    .clk      (clk),
    .rst_n    (rst_n),
    .req      (req),
    .prof_req (prof_req),
    .commit   (commit),
    .profile  (profile)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // fresh words, then one commit or one profile change
  task automatic trig(input bit prof);
    @(posedge clk) #1;
    freq_word  = freq_word + 32'h1357_9BDF;
    phase_word = phase_word + 14'h0ABD;
    amp_word   = amp_word + 10'h15B;
    if (prof) prof_req = prof_req + 4'h1;
    else req = 1'b1;
    @(posedge clk) #1 req = 1'b0;
  endtask

  // edge index of each landing mark; 0 if none in the window
  task automatic land;
    fk = 0; pk = 0; ak = 0;
    for (int k = 1; k <= 50; k++) begin
      @(posedge clk) #1;
      if (freq_upd_r === 1'b1) fk = k;
      if (phase_upd_r === 1'b1) pk = k;
      if (amp_upd_r === 1'b1) ak = k;
    end
  endtask

  // two strobes, each with its own landing window; the pin edge is seen one edge late and
  // the synchroniser adds one more before the pipeline count starts
  task automatic t_single;
    mode = 2'b00; match_en = 1'b0;
    repeat (2) begin
      trig(1'b0); land;
      `CHK(fk, sulp_pkg::LAT_ST_FREQ + 2)
      `CHK(pk, sulp_pkg::LAT_ST_PHASE + 2)
      `CHK(ak, sulp_pkg::LAT_ST_AMP + 2)
      `CHK({out_freq_r, out_amp_r}, {freq_word, amp_word})
    end
  endtask

  task automatic t_match;
    match_en = 1'b1;
    trig(1'b0); land;
    `CHK({fk, pk, ak}, {3{sulp_pkg::LAT_ST_MATCHED + 2}})
    `CHK(out_phase_r, phase_word)
  endtask

  task automatic t_profile;
    mode = 2'b01;
    trig(1'b1); land;
    `CHK(fk, sulp_pkg::LAT_PR_FREQ + 2)
    `CHK(pk, sulp_pkg::LAT_PR_PHASE + 2)
    `CHK(ak, sulp_pkg::LAT_PR_AMP + 2)
  endtask

  task automatic t_sweep;
    mode = 2'b10;
    trig(1'b1); land;
    `CHK(fk, sulp_pkg::LAT_SW_FREQ + 2)
    `CHK(pk, sulp_pkg::LAT_SW_PHASE + 2)
    `CHK(ak, sulp_pkg::LAT_SW_AMP + 2)
  endtask

  // ignored mode: neither strobe nor pins may move the outputs
  task automatic t_idle;
    mode = 2'b11;
    trig(1'b0); trig(1'b1); land;
    `CHK(fk + pk + ak, 0)
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #20000;
    mismatches++;
    finish_test;
  end

  initial begin
    mismatches = 0; n_compared = 0; rst_n = 1'b0; req = 1'b0;
    mode = 2'b00; match_en = 1'b0; prof_req = 4'h0;
    freq_word = 32'h0; phase_word = 14'h0; amp_word = 10'h0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    t_single; t_match; t_profile; t_sweep; t_idle;
    finish_test;
  end
endmodule

`default_nettype wire
